// ==== hw/ceef_pkg.sv ====
// package: register map, field positions and constants for the error event flag block
package ceef_pkg;
  // register offsets (byte addresses within the channel window)
  localparam logic [19:0] CEEF_CAN0_FLAG_OFF = 20'h47F4D;
  localparam logic [19:0] CEEF_CAN1_FLAG_OFF = 20'h47B4D;
  localparam logic [19:0] CEEF_CAN0_IEN_OFF = 20'h47F4C;
  localparam logic [19:0] CEEF_CAN1_IEN_OFF = 20'h47B4C;
  localparam logic [19:0] CEEF_CAN0_REC_OFF = 20'h47F4E;
  localparam logic [19:0] CEEF_CAN1_REC_OFF = 20'h47B4E;
  localparam logic [19:0] CEEF_CAN0_TEC_OFF = 20'h47F4F;
  localparam logic [19:0] CEEF_CAN1_TEC_OFF = 20'h47B4F;
  localparam logic [19:0] CEEF_CAN0_CTL_OFF = 20'h47F40;
  localparam logic [19:0] CEEF_CAN1_CTL_OFF = 20'h47B40;
  // flag bit positions
  localparam int CEEF_BIT_BUS_ERR = 0;
  localparam int CEEF_BIT_WARN = 1;
  localparam int CEEF_BIT_PASSIVE = 2;
  localparam int CEEF_BIT_BO_ENTRY = 3;
  localparam int CEEF_BIT_BO_RECOV = 4;
  localparam int CEEF_BIT_OVERRUN = 5;
  localparam int CEEF_BIT_OVERLOAD = 6;
  localparam int CEEF_BIT_BUS_LOCK = 7;
  // control register fields: mode [1:0], busoff handling [3:2], forced recovery [4]
  localparam int CEEF_CTL_MODE_LSB = 0;
  localparam int CEEF_CTL_BOH_LSB = 2;
  localparam int CEEF_CTL_FORCE_BIT = 4;
  // reset values
  localparam logic [7:0] CEEF_FLAG_RST = 8'h00;
  localparam logic [7:0] CEEF_IEN_RST = 8'h00;
  localparam logic [7:0] CEEF_CTL_RST = 8'h01;
  // thresholds
  localparam logic [8:0] CEEF_WARN_LIMIT = 9'h05F;
  localparam logic [8:0] CEEF_PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] CEEF_BUSOFF_LIMIT = 9'h0FF;
  localparam int CEEF_LOCK_BITS = 32;
  localparam int CEEF_RECOV_SEQ = 128;
  localparam int CEEF_RECOV_BITS = 11;
  localparam int CEEF_NORMAL_MBOX = 32;
  localparam int CEEF_FIFO_MBOX = 24;
  // operating modes and busoff handling codes
  typedef enum logic [1:0] {
    CEEF_MODE_OPER = 2'b00,
    CEEF_MODE_RESET = 2'b01,
    CEEF_MODE_HALT = 2'b10,
    CEEF_MODE_SLEEP = 2'b11
  } ceef_mode_t;
  localparam logic [1:0] CEEF_BOH_AUTO_HALT = 2'b01;
  localparam logic [1:0] CEEF_BOH_HALT_REQ = 2'b11;
  // channel register decode
  typedef enum logic [2:0] {
    CEEF_REG_NONE = 3'h0,
    CEEF_REG_FLAG = 3'h1,
    CEEF_REG_IEN = 3'h2,
    CEEF_REG_REC = 3'h3,
    CEEF_REG_TEC = 3'h4,
    CEEF_REG_CTL = 3'h5
  } ceef_reg_t;
endpackage

// ==== hw/ceef_threshold_arm.sv ====
// threshold crossing detector that fires once per rise above a limit
`timescale 1ns/1ps
`default_nettype none
module ceef_threshold_arm #(
  parameter logic [8:0] LIMIT = 9'h05F
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [8:0] rec_i,
  input wire logic [8:0] tec_i,
  output logic rise_o
);
  logic armed_q;
  logic above;
  logic below;
  // above when either count exceeds, re-arm only when both have fallen below
  assign above = (rec_i > LIMIT) || (tec_i > LIMIT);
  assign below = (rec_i < LIMIT) && (tec_i < LIMIT);
  assign rise_o = armed_q && above;
  // once fired the detector stays quiet until both counts drop, so a clear cannot retrigger
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      armed_q <= 1'b1;
    end else if (rise_o) begin
      armed_q <= 1'b0;
    end else if (below) begin
      armed_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== hw/ceef_channel.sv ====
// one channel: error event flags, their set sources from counts and bus events, and clear writes for one controller
`timescale 1ns/1ps
`default_nettype none
module ceef_channel (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic flag_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] busoff_hdl_i,
  input wire logic force_rec_i,
  input wire logic fifo_mode_i,
  input wire logic bus_error_i,
  input wire logic [8:0] rec_i,
  input wire logic [8:0] tec_i,
  input wire logic recovery_done_i,
  input wire logic [31:0] mbox_overrun_i,
  input wire logic [31:0] mbox_overrun_mode_i,
  input wire logic fifo_overrun_i,
  input wire logic fifo_overrun_mode_i,
  input wire logic overload_i,
  input wire logic bit_valid_i,
  input wire logic bit_dominant_i,
  output logic [7:0] flags_o
);
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic [7:0] set_ev;
  logic warn_rise;
  logic passive_rise;
  logic busoff_q;
  logic busoff_now;
  logic bo_entry;
  logic recov_blocked_q;
  logic [5:0] dom_cnt_q;
  logic lock_armed_q;
  logic lock_hit;
  logic oper;
  logic [1:0] mode_prev_q;
  logic left_oper_q;
  logic overrun_hit;
  logic [31:0] mbox_mask;

  ceef_threshold_arm #(
    .LIMIT(ceef_pkg::CEEF_WARN_LIMIT)
  ) u_warn (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .rec_i(rec_i),
    .tec_i(tec_i),
    .rise_o(warn_rise)
  );

  ceef_threshold_arm #(
    .LIMIT(ceef_pkg::CEEF_PASSIVE_LIMIT)
  ) u_passive (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .rec_i(rec_i),
    .tec_i(tec_i),
    .rise_o(passive_rise)
  );

  // bus-off entry: the counter has passed 255, whatever the handling setting
  assign busoff_now = (tec_i > ceef_pkg::CEEF_BUSOFF_LIMIT);
  assign bo_entry = busoff_now && !busoff_q;
  assign oper = (mode_i == ceef_pkg::CEEF_MODE_OPER);
  // fifo mode only watches mailboxes below the fifo region
  assign mbox_mask = fifo_mode_i ? 32'h00FFFFFF : 32'hFFFFFFFF;
  assign overrun_hit = |(mbox_overrun_i & mbox_overrun_mode_i & mbox_mask)
                     || (fifo_mode_i && fifo_overrun_i && fifo_overrun_mode_i);
  assign lock_hit = oper && lock_armed_q && bit_valid_i && bit_dominant_i
                  && (dom_cnt_q == 6'(ceef_pkg::CEEF_LOCK_BITS - 1));

  // set sources per flag
  always_comb begin
    set_ev = 8'h00;
    set_ev[ceef_pkg::CEEF_BIT_BUS_ERR] = bus_error_i;
    set_ev[ceef_pkg::CEEF_BIT_WARN] = warn_rise;
    set_ev[ceef_pkg::CEEF_BIT_PASSIVE] = passive_rise;
    set_ev[ceef_pkg::CEEF_BIT_BO_ENTRY] = bo_entry;
    set_ev[ceef_pkg::CEEF_BIT_BO_RECOV] = recovery_done_i && !recov_blocked_q
                                         && (busoff_hdl_i != ceef_pkg::CEEF_BOH_AUTO_HALT);
    set_ev[ceef_pkg::CEEF_BIT_OVERRUN] = overrun_hit;
    set_ev[ceef_pkg::CEEF_BIT_OVERLOAD] = overload_i;
    set_ev[ceef_pkg::CEEF_BIT_BUS_LOCK] = lock_hit;
  end

  // software writes zeros to clear, ones keep; hardware set wins over clear
  assign flag_d = ((flag_wr_i ? (flag_q & wdata_i) : flag_q)) | set_ev;
  assign flags_o = flag_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flag_q <= ceef_pkg::CEEF_FLAG_RST;
      busoff_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      busoff_q <= busoff_now;
    end
  end

  // recovery by reset mode, forced recovery or a halt request blocks the flag until next entry
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      recov_blocked_q <= 1'b0;
    end else if (bo_entry) begin
      recov_blocked_q <= 1'b0;
    end else if (busoff_q && (mode_i == ceef_pkg::CEEF_MODE_RESET || force_rec_i)) begin
      recov_blocked_q <= 1'b1;
    end else if (busoff_q && busoff_hdl_i == ceef_pkg::CEEF_BOH_HALT_REQ
                 && mode_i == ceef_pkg::CEEF_MODE_HALT) begin
      recov_blocked_q <= 1'b1;
    end
  end

  // dominant run counter; recessive bit resets it and, while the lock flag is clear, re-arms lock detection
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dom_cnt_q <= 6'h00;
      lock_armed_q <= 1'b1;
      mode_prev_q <= ceef_pkg::CEEF_MODE_RESET;
      left_oper_q <= 1'b0;
    end else begin
      mode_prev_q <= mode_i;
      if (!oper) begin
        dom_cnt_q <= 6'h00;
        if (mode_i == ceef_pkg::CEEF_MODE_RESET || mode_i == ceef_pkg::CEEF_MODE_HALT) begin
          left_oper_q <= 1'b1;
        end
      end else if (bit_valid_i) begin
        dom_cnt_q <= bit_dominant_i ? ((dom_cnt_q == 6'h3F) ? dom_cnt_q : dom_cnt_q + 6'h01)
                                    : 6'h00;
      end
      if (lock_hit) begin
        lock_armed_q <= 1'b0;
      end else if (bit_valid_i && !bit_dominant_i && !flag_q[ceef_pkg::CEEF_BIT_BUS_LOCK]) begin
        lock_armed_q <= 1'b1;
      end else if (oper && left_oper_q && mode_prev_q != ceef_pkg::CEEF_MODE_OPER) begin
        lock_armed_q <= 1'b1;
        left_oper_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/ceef_top.sv ====
// top: register port for both channels' error event flags, enables, counters and control
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - flags set on their event regardless of the enable bits
// - writing 0 clears a flag, writing 1 leaves it alone
// - a set in the same cycle as a clear leaves the flag set
// - bus error flag sets on any detected bus error
// - warning flag sets when either error count rises above 95
// - after clear, warning re-sets only after both counts fell below 95
// - passive flag sets when either error count rises above 127
// - after clear, passive re-sets only after both counts fell below 127
// - bus-off entry flag sets when transmit count passes 255, any handling setting
// - recovery flag sets on normal recovery for handling 00b, 10b, 11b
// - no recovery flag when left via reset mode or forced recovery
// - handling 01b never sets the recovery flag
// - handling 11b sets recovery only if recovery precedes a halt request
// - overrun flag only for overrun-mode mailboxes, never overwrite mode
// - normal mailbox mode watches mailboxes 0 to 31
// - fifo mailbox mode watches mailboxes 0 to 23 and the receive fifo
// - overload flag sets when an overload frame is required
// - bus lock flag sets on 32 dominant bits in operation mode
// - bus lock re-arms on recessive bits while its flag is clear, or a pass through reset or halt
// - receive error count readable
// - transmit error count readable
// - a flag requests an interrupt only when its enable is 1
module ceef_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] fifo_mode_i,
  input wire logic [1:0] bus_error_i,
  input wire logic [17:0] rec_i,
  input wire logic [17:0] tec_i,
  input wire logic [1:0] recovery_done_i,
  input wire logic [63:0] mbox_overrun_i,
  input wire logic [63:0] mbox_overrun_mode_i,
  input wire logic [1:0] fifo_overrun_i,
  input wire logic [1:0] fifo_overrun_mode_i,
  input wire logic [1:0] overload_i,
  input wire logic [1:0] bit_valid_i,
  input wire logic [1:0] bit_dominant_i,
  output logic [3:0] mode_o,
  output logic [3:0] busoff_hdl_o,
  output logic [1:0] error_irq_o
);
  logic [7:0] ien_q [2];
  logic [7:0] ctl_q [2];
  logic [7:0] flags [2];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_ch;
  ceef_pkg::ceef_reg_t reg_sel;

  // map an address onto channel and register
  function automatic ceef_pkg::ceef_reg_t decode(input logic [19:0] a, input logic ch);
    ceef_pkg::ceef_reg_t r;
    r = ceef_pkg::CEEF_REG_NONE;
    if (a == (ch ? ceef_pkg::CEEF_CAN1_FLAG_OFF : ceef_pkg::CEEF_CAN0_FLAG_OFF)) begin
      r = ceef_pkg::CEEF_REG_FLAG;
    end else if (a == (ch ? ceef_pkg::CEEF_CAN1_IEN_OFF : ceef_pkg::CEEF_CAN0_IEN_OFF)) begin
      r = ceef_pkg::CEEF_REG_IEN;
    end else if (a == (ch ? ceef_pkg::CEEF_CAN1_REC_OFF : ceef_pkg::CEEF_CAN0_REC_OFF)) begin
      r = ceef_pkg::CEEF_REG_REC;
    end else if (a == (ch ? ceef_pkg::CEEF_CAN1_TEC_OFF : ceef_pkg::CEEF_CAN0_TEC_OFF)) begin
      r = ceef_pkg::CEEF_REG_TEC;
    end else if (a == (ch ? ceef_pkg::CEEF_CAN1_CTL_OFF : ceef_pkg::CEEF_CAN0_CTL_OFF)) begin
      r = ceef_pkg::CEEF_REG_CTL;
    end
    return r;
  endfunction

  // channel 1 wins decode when it matches, otherwise channel 0
  assign hit_ch = (decode(addr_i, 1'b1) != ceef_pkg::CEEF_REG_NONE);
  assign reg_sel = decode(addr_i, hit_ch);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic fwr;
    // software clears flags with a whole-byte write of ones except the target
    assign fwr = wr_i && (hit_ch == 1'(c)) && (reg_sel == ceef_pkg::CEEF_REG_FLAG);
    ceef_channel u_ch (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .flag_wr_i(fwr),
      .wdata_i(wdata_i),
      .mode_i(ctl_q[c][ceef_pkg::CEEF_CTL_MODE_LSB +: 2]),
      .busoff_hdl_i(ctl_q[c][ceef_pkg::CEEF_CTL_BOH_LSB +: 2]),
      .force_rec_i(ctl_q[c][ceef_pkg::CEEF_CTL_FORCE_BIT]),
      .fifo_mode_i(fifo_mode_i[c]),
      .bus_error_i(bus_error_i[c]),
      .rec_i(rec_i[9*c +: 9]),
      .tec_i(tec_i[9*c +: 9]),
      .recovery_done_i(recovery_done_i[c]),
      .mbox_overrun_i(mbox_overrun_i[32*c +: 32]),
      .mbox_overrun_mode_i(mbox_overrun_mode_i[32*c +: 32]),
      .fifo_overrun_i(fifo_overrun_i[c]),
      .fifo_overrun_mode_i(fifo_overrun_mode_i[c]),
      .overload_i(overload_i[c]),
      .bit_valid_i(bit_valid_i[c]),
      .bit_dominant_i(bit_dominant_i[c]),
      .flags_o(flags[c])
    );
    // request held while any enabled flag stays set
    assign error_irq_o[c] = |(flags[c] & ien_q[c]);
    assign mode_o[2*c +: 2] = ctl_q[c][ceef_pkg::CEEF_CTL_MODE_LSB +: 2];
    assign busoff_hdl_o[2*c +: 2] = ctl_q[c][ceef_pkg::CEEF_CTL_BOH_LSB +: 2];

    // enable and control registers; forced recovery bit self-clears after one cycle
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        ien_q[c] <= ceef_pkg::CEEF_IEN_RST;
        ctl_q[c] <= ceef_pkg::CEEF_CTL_RST;
      end else begin
        ctl_q[c][ceef_pkg::CEEF_CTL_FORCE_BIT] <= 1'b0;
        if (wr_i && hit_ch == 1'(c) && reg_sel == ceef_pkg::CEEF_REG_IEN) begin
          ien_q[c] <= wdata_i;
        end
        if (wr_i && hit_ch == 1'(c) && reg_sel == ceef_pkg::CEEF_REG_CTL) begin
          ctl_q[c] <= wdata_i & 8'h1F;
        end
      end
    end
  end

  // read mux; counters read as their low 8 bits with bit 8 saturating to FF
  always_comb begin
    rdata_d = 8'h00;
    case (reg_sel)
      ceef_pkg::CEEF_REG_FLAG: rdata_d = flags[hit_ch];
      ceef_pkg::CEEF_REG_IEN: rdata_d = ien_q[hit_ch];
      ceef_pkg::CEEF_REG_REC: begin
        rdata_d = sat8(rec_i[9*hit_ch +: 9]);
      end
      ceef_pkg::CEEF_REG_TEC: begin
        rdata_d = sat8(tec_i[9*hit_ch +: 9]);
      end
      ceef_pkg::CEEF_REG_CTL: rdata_d = ctl_q[hit_ch];
      default: rdata_d = 8'h00;
    endcase
  end

  function automatic logic [7:0] sat8(input logic [8:0] v);
    return v[8] ? 8'hFF : v[7:0];
  endfunction

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rdata_d : 8'h00;
    end
  end
  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ==== dv/ceef_bus_model.sv ====
// bus partner: sends dominant bits then recessive bits, one bit every four clocks
`timescale 1ns/1ps
`default_nettype none
module ceef_bus_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic ch_i,
  input wire logic [6:0] ndom_i,
  input wire logic [1:0] nrec_i,
  output logic [1:0] bit_valid_o,
  output logic [1:0] bit_dominant_o,
  output logic busy_o
);
  logic [7:0] left_q;
  logic [1:0] div_q;
  assign busy_o = left_q != 8'h00;
  // run length and channel are held by the bench for the whole run, so no copy here
  // between strobes the bit level flips every clock so a stale level is never trusted
  always_ff @(posedge clk_sys_i) begin
    bit_valid_o <= 2'h0;
    bit_dominant_o <= ~bit_dominant_o;
    div_q <= div_q + 2'h1;
    if (reset_i) begin
      left_q <= 8'h00;
      div_q <= 2'h0;
      bit_dominant_o <= 2'h0;
    end else if (go_i) begin
      left_q <= 8'(ndom_i) + 8'(nrec_i);
    end else if (busy_o && div_q == 2'h0) begin
      left_q <= left_q - 8'h01;
      bit_valid_o[ch_i] <= 1'b1;
      bit_dominant_o[ch_i] <= left_q > 8'(nrec_i);
    end
  end
endmodule
`default_nettype wire

// ==== dv/ceef_top_asserts.sv ====
// checker: channel 0 request timing against its causes at the top ports
`timescale 1ns/1ps
`default_nettype none
module ceef_top_asserts (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic [1:0] fifo_mode_i,
  input wire logic [1:0] bus_error_i,
  input wire logic [17:0] rec_i,
  input wire logic [17:0] tec_i,
  input wire logic [63:0] mbox_overrun_i,
  input wire logic [63:0] mbox_overrun_mode_i,
  input wire logic [1:0] overload_i,
  input wire logic [1:0] bit_valid_i,
  input wire logic [1:0] bit_dominant_i,
  input wire logic [3:0] mode_o,
  input wire logic [1:0] error_irq_o
);
  logic [7:0] ien_q;
  logic [5:0] run_q;
  logic arm_q;
  // decode of the writes and events that the properties key on
  wire ien_wr = wr_i && addr_i == ceef_pkg::CEEF_CAN0_IEN_OFF;
  wire clr_wr = wr_i && addr_i == ceef_pkg::CEEF_CAN0_FLAG_OFF && wdata_i == 8'h00;
  wire dom_bit = bit_valid_i[0] && bit_dominant_i[0] && mode_o[1:0] == 2'b00;
  wire orun = |(mbox_overrun_i[31:0] & mbox_overrun_mode_i[31:0]) && !fifo_mode_i[0];
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // shadow of the enable register; updates on the same edge as the block's copy
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) ien_q <= 8'h00;
    else if (ien_wr) ien_q <= wdata_i;
  end
  // dominant run in operation mode; arm drops at a lock until the next recessive bit re-arms it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || (bit_valid_i[0] && !bit_dominant_i[0])) begin
      run_q <= 6'h00;
      arm_q <= 1'b1;
    end else if (mode_o[1:0] != 2'b00) run_q <= 6'h00;
    else if (dom_bit && run_q != 6'h3F) begin
      run_q <= run_q + 6'h01;
      if (run_q == 6'h1F) arm_q <= 1'b0;
    end
  end
  irq_after_reset_a: assert property ($fell(reset_i) |-> error_irq_o == 2'b00)
    else $error("request high just after reset");
  irq_gate_a: assert property (ien_q == 8'h00 |-> !error_irq_o[0])
    else $error("request with all enables off");
  bus_err_set_a: assert property (bus_error_i[0] && ien_q[0] && !ien_wr |=> error_irq_o[0])
    else $error("bus error gave no request");
  set_wins_a: assert property (bus_error_i[0] && clr_wr && ien_q[0] |=> error_irq_o[0])
    else $error("clear beat a same cycle set");
  overload_set_a: assert property (overload_i[0] && ien_q[6] && !ien_wr |=> error_irq_o[0])
    else $error("overload gave no request");
  overrun_set_a: assert property (orun && ien_q[5] && !ien_wr |=> error_irq_o[0])
    else $error("mailbox overrun gave no request");
  warn_rise_a: assert property ($past(rec_i[8:0]) < 9'h05F && $past(tec_i[8:0]) < 9'h05F &&
    rec_i[8:0] > 9'h05F && ien_q[1] && !ien_wr |=> error_irq_o[0])
    else $error("warning rise gave no request");
  lock_set_a: assert property (dom_bit && run_q == 6'h1F && arm_q && ien_q[7] |=> error_irq_o[0])
    else $error("bus lock gave no request");
  cover property (bus_error_i[0] && clr_wr);
  cover property (dom_bit && run_q == 6'h1F);
  cover property ($rose(error_irq_o[0]));
endmodule
bind ceef_top ceef_top_asserts chk_u (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// testbench: both channels through flag, count, recovery, overrun and lock cases
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0, busy;
  logic [19:0] addr_i = 20'h00000, fa, ca;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [1:0] fifo_mode_i = 2'h0, bus_error_i = 2'h0, recovery_done_i = 2'h0, overload_i = 2'h0;
  logic [1:0] fifo_overrun_i = 2'h0, fifo_overrun_mode_i = 2'h0, bit_valid_i, bit_dominant_i;
  logic [1:0] error_irq_o, nrec = 2'h0;
  logic [3:0] mode_o, busoff_hdl_o;
  logic [6:0] ndom = 7'h00;
  logic [17:0] rec_i = 18'h00000, tec_i = 18'h00000;
  logic [63:0] mbox_overrun_i = 64'h0, mbox_overrun_mode_i = 64'h0;
  int n_errors = 0, checks = 0, seed = 76552, cyc = 0, ch = 0, mi, j, k, mf[2], am[2][3];
  int cr[10] = '{100, 120, 94, 96, 130, 140, 0, 0, 0, 0};
  int ct[10] = '{0, 0, 50, 0, 0, 20, 0, 200, 256, 0};
  int bm[7] = '{0, 1, 2, 3, 3, 0, 0};
  int md[7] = '{0, 0, 0, 0, 14, 16, 1};
  int ex[7] = '{1, 0, 1, 1, 0, 0, 0};
  ceef_top dut_u (.*);
  ceef_bus_model bus_u (.clk_sys_i, .reset_i, .go_i(go), .ch_i(ch[0]), .ndom_i(ndom),
    .nrec_i(nrec), .bit_valid_o(bit_valid_i), .bit_dominant_o(bit_dominant_i), .busy_o(busy));
  always #2 clk_sys_i = ~clk_sys_i;
  // a hung wait is cut short well past the few thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  // register write; the model follows flag clears and enable writes
  task automatic wr(logic [19:0] a, logic [7:0] d);
    @(posedge clk_sys_i) begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
    end
    @(posedge clk_sys_i) wr_i <= 1'b0;
    if (a == fa) mf[ch] &= d;
    if (a == fa - 1) mi = d;
  endtask
  task automatic rd(logic [19:0] a, logic [7:0] e);
    @(posedge clk_sys_i) begin
      addr_i <= a;
      rd_i <= 1'b1;
    end
    @(posedge clk_sys_i) rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, rdata_o});
  endtask
  task automatic cf();
    rd(fa, 8'(mf[ch]));
    chk("irq", 9'((mf[ch] & mi) != 0), 9'(error_irq_o[ch]));
  endtask
  task automatic pulse(int w, int m);
    @(posedge clk_sys_i) case (w)
      0: bus_error_i[ch] <= 1'b1;
      1: overload_i[ch] <= 1'b1;
      default: recovery_done_i[ch] <= 1'b1;
    endcase
    @(posedge clk_sys_i) begin
      bus_error_i <= 2'h0;
      overload_i <= 2'h0;
      recovery_done_i <= 2'h0;
    end
    mf[ch] |= m;
  endtask
  // counts change; the model sets a flag on a rise past a limit from an armed state
  task automatic cnt(int r, int t);
    int lim, mx;
    @(posedge clk_sys_i) begin
      rec_i[ch*9+:9] <= 9'(r);
      tec_i[ch*9+:9] <= 9'(t);
    end
    for (k = 0; k < 3; k++) begin
      lim = k == 2 ? 255 : (k == 1 ? 127 : 95);
      mx = k == 2 ? t : (r > t ? r : t);
      if (mx > lim && am[ch][k]) begin
        mf[ch] |= 2 << k;
        am[ch][k] = 0;
      end
      if (mx < lim || (k == 2 && mx == lim)) am[ch][k] = 1;
    end
    @(posedge clk_sys_i);
    cf();
    rd(fa + 1, r > 255 ? 8'hFF : 8'(r));
    rd(fa + 2, t > 255 ? 8'hFF : 8'(t));
  endtask
  task automatic bits(int n, int r, int m);
    int i;
    @(posedge clk_sys_i) begin
      ndom <= 7'(n);
      nrec <= 2'(r);
      go <= 1'b1;
    end
    @(posedge clk_sys_i) go <= 1'b0;
    #1;
    for (i = 0; i < 400 && busy; i++) @(posedge clk_sys_i);
    mf[ch] |= m;
    cf();
  endtask
  initial begin
    for (j = 0; j < 6; j++) am[j/3][j%3] = 1;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (ch = 0; ch < 2; ch++) begin
      fa = ch ? ceef_pkg::CEEF_CAN1_FLAG_OFF : ceef_pkg::CEEF_CAN0_FLAG_OFF;
      ca = ch ? ceef_pkg::CEEF_CAN1_CTL_OFF : ceef_pkg::CEEF_CAN0_CTL_OFF;
      mf[ch] = 0;
      mi = 0;
      rd(fa, 8'h00);
      rd(ca, 8'h01);
      wr(fa + 1, 8'h55);
      rd(fa + 1, 8'h00);
      wr(fa + 3, 8'hFF);
      rd(fa + 3, 8'h00);
      wr(ca, 8'h00);
      pulse(0, 1);
      cf();
      wr(fa - 1, 8'hFF);
      cf();
      wr(fa, 8'hFF);
      cf();
      wr(fa, 8'hFE);
      cf();
      // set and clear meet in one cycle
      @(posedge clk_sys_i) begin
        bus_error_i[ch] <= 1'b1;
        addr_i <= fa;
        wdata_i <= 8'h00;
        wr_i <= 1'b1;
      end
      @(posedge clk_sys_i) begin
        bus_error_i <= 2'h0;
        wr_i <= 1'b0;
      end
      mf[ch] = 1;
      cf();
      pulse(1, 'h40);
      cf();
      // random mailbox, fifo, overrun mode and mailbox mode per round
      for (j = 0; j < 24; j++) begin
        k = $random(seed);
        @(posedge clk_sys_i) begin
          fifo_mode_i[ch] <= k[6];
          fifo_overrun_mode_i[ch] <= k[5];
          mbox_overrun_mode_i[ch*32+k[4:0]] <= k[5];
        end
        @(posedge clk_sys_i) if (k[7]) fifo_overrun_i[ch] <= 1'b1;
        else mbox_overrun_i[ch*32+k[4:0]] <= 1'b1;
        @(posedge clk_sys_i) begin
          fifo_overrun_i <= 2'h0;
          mbox_overrun_i <= 64'h0;
        end
        if (k[5] && (k[7] ? k[6] : (!k[6] || k[4:0] < 24))) mf[ch] |= 'h20;
        cf();
        wr(fa, 8'hDF);
      end
      wr(fa, 8'h00);
      for (j = 0; j < 10; j++) begin
        cnt(cr[j], ct[j]);
        wr(fa, 8'h00);
      end
      for (j = 0; j < 7; j++) begin
        wr(ca, 8'(bm[j] << 2));
        // the control register settles on the write's edge, so look one step later
        #1 chk("busoff handling", 9'(bm[j]), 9'(busoff_hdl_o[ch*2+:2]));
        chk("mode", 9'h000, 9'(mode_o[ch*2+:2]));
        cnt(0, 256);
        if (md[j] != 0) wr(ca, 8'(md[j]));
        pulse(2, ex[j] << 4);
        cnt(0, 0);
        wr(fa, 8'h00);
      end
      wr(ca, 8'h00);
      bits(32, 0, 'h80);
      wr(fa, 8'h7F);
      bits(5, 0, 0);
      bits(0, 1, 0);
      bits(31, 1, 0);
      bits(32, 0, 'h80);
      wr(fa, 8'h7F);
      wr(ca, 8'h01);
      bits(32, 0, 0);
      wr(ca, 8'h00);
      bits(32, 0, 'h80);
    end
    final_report();
  end
endmodule
`default_nettype wire
